// [core/axis_homing_sequencer.sv]
// Purpose: homing sequencer for one motion axis, modes 0 to 4
// Assumes: inputs synchronous to i_clk; switches already debounced
// Notes:   origin latch pulses on the captured index edge
//          no timeout: a switch or index that never shows keeps busy high
//          configuration must hold still while busy; it is read live
//          a forced search or absolute reset searches afresh in modes 1 to 4; mode 0 takes current position
// Contract
// - mode 1 reverse at sensor, take index
// - mode 2 pass sensor, take index
// - mode 3 index search at second speed
// - mode 4 limit as home, reverse, index
// - mode 4 direction bit picks limit
// - axis type 0 incremental, 1 absolute
// - incremental without origin searches, not retained
// - absolute searches if unset or forced, retained
// - origin set, not forced: return to origin
// - mode 3 forced: index search again
// - mode 3 unset: search index by direction
// - mode 3 linear return at first speed
// - mode 3 rotary nearest or machine origin
// - absolute reset searches; incremental ignores it
// - mode 0 takes current position
`timescale 1ns/10ps
`default_nettype none

module axis_homing_sequencer (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // configuration
    input  wire logic [5:0]           i_homing_mode_select,
    input  wire logic                 i_axis_type_select,
    input  wire logic [2:0]           i_homing_option_bits,
    input  wire logic                 i_rotary_axis,
    // requests
    input  wire logic                 i_home_request,
    input  wire logic                 i_abs_origin_reset,
    input  wire logic                 i_power_up,
    // axis sensing
    input  wire homing_pkg::axis_sense_t i_sense,
    // motion command and status
    output homing_pkg::motion_cmd_t   o_cmd,
    output logic                      o_origin_latch,
    output logic                      o_origin_valid,
    output logic                      o_origin_retained,
    output logic                      o_busy,
    output logic                      o_ignored
);

    // sequence state and per-run bookkeeping
    homing_pkg::home_state_t state;
    homing_pkg::home_state_t next_state;
    logic                    reversed;
    logic                    nearest_run;

    // decoded configuration
    logic dir_pos;
    logic force_search;
    logic is_absolute;
    logic mode_switch;
    logic mode_known;
    logic start_req;
    logic abs_cmd;
    logic need_search;
    logic reverse_mode;
    logic nearest_now;
    logic index_hit;
    logic take_current;

    assign is_absolute  = (i_axis_type_select == homing_pkg::AXIS_ABSOLUTE);
    // option bits and switch-mode classes
    assign dir_pos      = i_homing_option_bits[homing_pkg::OPT_DIR];
    assign force_search = i_homing_option_bits[homing_pkg::OPT_FORCE];
    assign mode_switch  = (i_homing_mode_select == homing_pkg::MODE_REVERSE)
                       || (i_homing_mode_select == homing_pkg::MODE_PASS)
                       || (i_homing_mode_select == homing_pkg::MODE_LIMIT);
    assign mode_known   = mode_switch
                       || (i_homing_mode_select == homing_pkg::MODE_INDEX)
                       || (i_homing_mode_select == homing_pkg::MODE_CURRENT);
    // absolute reset only acts on an absolute axis
    assign abs_cmd      = i_abs_origin_reset && is_absolute;
    assign start_req    = (i_home_request || abs_cmd) && mode_known;
    // search when no origin, forced, or absolute reset
    assign need_search  = !o_origin_valid || force_search || abs_cmd;

    // function: the switch that acts as home in the current mode
    function automatic logic home_switch(input logic [5:0] mode,
                                         input homing_pkg::axis_sense_t s,
                                         input logic dpos);
        logic hit;
        hit = s.home_sensor;
        if (mode == homing_pkg::MODE_LIMIT) begin
            hit = dpos ? s.limit_pos : s.limit_neg;
        end
        return hit;
    endfunction : home_switch

    // function: modes that turn back once the switch is reached
    function automatic logic turns_back(input logic [5:0] mode);
        logic back;
        back = 1'b0;
        if ((mode == homing_pkg::MODE_REVERSE)
            || (mode == homing_pkg::MODE_LIMIT)) begin
            back = 1'b1;
        end
        return back;
    endfunction : turns_back

    logic at_switch;
    assign at_switch = home_switch(i_homing_mode_select, i_sense, dir_pos);

    assign reverse_mode = turns_back(i_homing_mode_select);
    // nearest run known while still idle
    assign nearest_now  = (state == homing_pkg::ST_IDLE)
                        ? ((next_state == homing_pkg::ST_SEEK_INDEX)
                           && !need_search)
                        : nearest_run;
    // index edge met during the search
    assign index_hit    = (state == homing_pkg::ST_SEEK_INDEX)
                        && i_sense.index_pulse;
    assign take_current = (state == homing_pkg::ST_IDLE) && start_req
                        && (i_homing_mode_select
                            == homing_pkg::MODE_CURRENT);

    // next state of the sequence
    always_comb begin
        next_state = state;
        unique case (state)
            homing_pkg::ST_IDLE: begin
                if (start_req) begin
                    if (i_homing_mode_select == homing_pkg::MODE_CURRENT) begin
                        next_state = homing_pkg::ST_DONE;
                    end else if (need_search) begin
                        // mode 3 goes straight to index
                        next_state = mode_switch ? homing_pkg::ST_SEEK_SWITCH
                                                 : homing_pkg::ST_SEEK_INDEX;
                    end else if (i_homing_mode_select == homing_pkg::MODE_INDEX
                                 && i_rotary_axis
                                 && i_homing_option_bits[homing_pkg::OPT_NEAREST])
                    begin
                        next_state = homing_pkg::ST_SEEK_INDEX;
                    end else begin
                        next_state = homing_pkg::ST_RETURN;
                    end
                end
            end
            homing_pkg::ST_SEEK_SWITCH: begin
                if (at_switch) begin
                    next_state = (i_homing_mode_select == homing_pkg::MODE_PASS)
                               ? homing_pkg::ST_LEAVE_SWITCH
                               : homing_pkg::ST_SEEK_INDEX;
                end
            end
            homing_pkg::ST_LEAVE_SWITCH: begin
                if (!at_switch) begin
                    next_state = homing_pkg::ST_SEEK_INDEX;
                end
            end
            homing_pkg::ST_SEEK_INDEX: begin
                if (i_sense.index_pulse) begin
                    next_state = homing_pkg::ST_DONE;
                end
            end
            homing_pkg::ST_RETURN: begin
                if (i_sense.at_origin) begin
                    next_state = homing_pkg::ST_DONE;
                end
            end
            homing_pkg::ST_DONE: begin
                // one cycle to report completion
                next_state = homing_pkg::ST_IDLE;
            end
            default: next_state = homing_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= homing_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // reversal flag: set once the switch is met in modes 1 and 4
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            reversed <= 1'b0;
        end else if (state == homing_pkg::ST_IDLE) begin
            reversed <= 1'b0;
        end else if (state == homing_pkg::ST_SEEK_SWITCH && at_switch) begin
            reversed <= reverse_mode;
        end
    end

    // nearest-origin run flag, fixed when the run starts
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            nearest_run <= 1'b0;
        end else if (state == homing_pkg::ST_IDLE) begin
            nearest_run <= nearest_now;
        end
    end

    // motion command toward the drive
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_cmd <= '{move: 1'b0, dir_pos: 1'b0,
                       speed: homing_pkg::RESET_SPEED, to_origin: 1'b0};
        end else begin
            // move while searching or returning
            o_cmd.move      <= (next_state != homing_pkg::ST_IDLE)
                            && (next_state != homing_pkg::ST_DONE);
            o_cmd.to_origin <= (next_state == homing_pkg::ST_RETURN);
            o_cmd.dir_pos   <= (next_state == homing_pkg::ST_SEEK_INDEX
                                && (reversed
                                    || (state == homing_pkg::ST_SEEK_SWITCH
                                        && at_switch && reverse_mode)))
                             ? !dir_pos : dir_pos;
            unique case (next_state)
                homing_pkg::ST_SEEK_INDEX:
                    // second speed; nearest run first speed
                    o_cmd.speed <= nearest_now ? homing_pkg::SPEED_FIRST
                                               : homing_pkg::SPEED_SECOND;
                homing_pkg::ST_SEEK_SWITCH,
                homing_pkg::ST_LEAVE_SWITCH,
                homing_pkg::ST_RETURN:
                    o_cmd.speed <= homing_pkg::SPEED_FIRST;
                default:
                    o_cmd.speed <= homing_pkg::SPEED_STOP;
            endcase
        end
    end

    // index capture marks the origin
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_origin_latch <= 1'b0;
        end else begin
            o_origin_latch <= index_hit || take_current;
        end
    end

    // origin status: retained only on an absolute axis
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_origin_valid    <= 1'b0;
            o_origin_retained <= 1'b0;
        end else if (state == homing_pkg::ST_DONE) begin
            // set on completion, wins over power-up
            o_origin_valid    <= 1'b1;
            o_origin_retained <= is_absolute;
        end else if (i_power_up && !o_origin_retained) begin
            o_origin_valid <= 1'b0;
        end
    end

    // busy flag: high while a sequence runs
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (next_state != homing_pkg::ST_IDLE);
        end
    end

    // ignored pulse for a refused absolute reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_ignored <= 1'b0;
        end else begin
            o_ignored <= i_abs_origin_reset && !is_absolute
                      && (state == homing_pkg::ST_IDLE);
        end
    end

endmodule : axis_homing_sequencer

`default_nettype wire

// [core/homing_pkg.sv]
// Purpose: shared constants and types for the axis homing sequencer
// Assumes: one axis, single 200 MHz clock
// Notes:   motion is commanded as direction/speed/move levels
package homing_pkg;

    // homing mode codes
    localparam logic [5:0] MODE_CURRENT = 6'h00;
    localparam logic [5:0] MODE_REVERSE = 6'h01;
    localparam logic [5:0] MODE_PASS    = 6'h02;
    localparam logic [5:0] MODE_INDEX   = 6'h03;
    localparam logic [5:0] MODE_LIMIT   = 6'h04;

    // axis type codes
    localparam logic AXIS_INCREMENTAL = 1'b0;
    localparam logic AXIS_ABSOLUTE    = 1'b1;

    // option bit positions
    localparam int OPT_DIR     = 0;
    localparam int OPT_FORCE   = 1;
    localparam int OPT_NEAREST = 2;

    // speed select codes
    localparam logic [1:0] SPEED_STOP   = 2'h0;
    localparam logic [1:0] SPEED_FIRST  = 2'h1;
    localparam logic [1:0] SPEED_SECOND = 2'h2;

    // reset values
    localparam logic [1:0] RESET_SPEED = 2'h0;

    // axis switches and encoder index
    typedef struct packed {
        logic home_sensor;
        logic limit_pos;
        logic limit_neg;
        logic index_pulse;
        logic at_origin;
    } axis_sense_t;

    // motion command toward the drive
    typedef struct packed {
        logic       move;
        logic       dir_pos;
        logic [1:0] speed;
        logic       to_origin;
    } motion_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEEK_SWITCH,
        ST_LEAVE_SWITCH,
        ST_SEEK_INDEX,
        ST_RETURN,
        ST_DONE
    } home_state_t;

endpackage : homing_pkg

// [test/axis_drive_model.sv]
// Purpose: drive, encoder and switch model of one axis
// Assumes: one count per cycle of motion
// Notes:   sensor at 20..23, limits at -40 and 40
`timescale 1ns/10ps
`default_nettype none

module axis_drive_model (
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    // commands from the sequencer
    input  wire homing_pkg::motion_cmd_t i_cmd,
    input  wire logic                    i_origin_latch,
    // switches and encoder index
    output homing_pkg::axis_sense_t      o_sense
);
    int pos;
    int org;

    // return steps toward the stored origin, else along dir_pos
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            pos <= 0;
            org <= 0;
        end else begin
            if (i_cmd.to_origin)
                pos <= pos + int'(org > pos) - int'(org < pos);
            else if (i_cmd.move)
                pos <= pos + (i_cmd.dir_pos ? 1 : -1);
            if (i_origin_latch)
                org <= pos;
        end
    end

    // index only shows while the shaft turns
    assign o_sense = '{home_sensor: pos >= 20 && pos <= 23,
                       limit_pos:   pos >= 40,
                       limit_neg:   pos <= -40,
                       index_pulse: i_cmd.move && pos % 8 == 0,
                       at_origin:   pos == org};
endmodule : axis_drive_model

`default_nettype wire

// [test/axis_homing_sequencer_props.sv]
// Purpose: port checks of the homing sequencer
// Assumes: configuration stays steady through a sequence
// Notes:   bound to every sequencer instance
`timescale 1ns/10ps
`default_nettype none

module homing_props (
    // clock and reset
    input wire logic                    i_clk,
    input wire logic                    i_rst_n,
    // configuration and requests
    input wire logic [5:0]              i_homing_mode_select,
    input wire logic                    i_axis_type_select,
    input wire logic [2:0]              i_homing_option_bits,
    input wire logic                    i_rotary_axis,
    input wire logic                    i_home_request,
    input wire logic                    i_abs_origin_reset,
    input wire logic                    i_power_up,
    input wire homing_pkg::axis_sense_t i_sense,
    // sequencer outputs
    input wire homing_pkg::motion_cmd_t o_cmd,
    input wire logic                    o_origin_latch,
    input wire logic                    o_origin_valid,
    input wire logic                    o_origin_retained,
    input wire logic                    o_busy,
    input wire logic                    o_ignored
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // request decode
    wire [5:0] md = i_homing_mode_select;
    wire dirb = i_homing_option_bits[0];
    wire m14 = md inside {6'h01, 6'h02, 6'h04};
    wire m3 = md == 6'h03;
    wire take = !o_busy
        && (i_home_request || i_abs_origin_reset && i_axis_type_select);
    wire srch = !o_origin_valid || i_homing_option_bits[1]
        || i_abs_origin_reset && i_axis_type_select;
    wire first = o_cmd.speed == homing_pkg::SPEED_FIRST;
    wire second = o_cmd.speed == homing_pkg::SPEED_SECOND;
    wire fwd = o_cmd.move && !o_cmd.to_origin;

    // start of each sequence
    AST_SEEK_START: assert property (
        take && m14 && srch |=> fwd && first && o_cmd.dir_pos == dirb)
        else $error("switch search did not start");
    AST_INDEX_START: assert property (
        take && m3 && srch |=> fwd && second && o_cmd.dir_pos == dirb)
        else $error("index search did not start");
    AST_RETURN: assert property (
        take && !srch && (m14 || m3
        && !(i_rotary_axis && i_homing_option_bits[2]))
        |=> o_cmd.to_origin && first)
        else $error("return to origin not commanded");
    AST_NEAREST: assert property (
        take && m3 && !srch && i_rotary_axis && i_homing_option_bits[2]
        |=> fwd && first && o_cmd.dir_pos == dirb)
        else $error("nearest origin search not started");
    AST_MODE0: assert property (
        take && md == 6'h00 |=> o_origin_latch)
        else $error("current position not taken");

    // switch reactions
    AST_REVERSE: assert property (
        o_busy && md == 6'h01 && i_sense.home_sensor && fwd && first
        |=> o_cmd.dir_pos != dirb && second)
        else $error("no reversal at home sensor");
    AST_PASS: assert property (
        o_busy && md == 6'h02 && i_sense.home_sensor && fwd
        |=> o_cmd.dir_pos == dirb)
        else $error("direction changed on home sensor");
    AST_LIMIT: assert property (
        o_busy && md == 6'h04 && fwd && first
        && (dirb ? i_sense.limit_pos : i_sense.limit_neg)
        |=> o_cmd.dir_pos != dirb && second)
        else $error("no reversal at selected limit");
    AST_LATCH: assert property (
        o_busy && md != 6'h02 && fwd && second && i_sense.index_pulse
        |=> o_origin_latch)
        else $error("index pulse not latched");

    // origin status
    AST_VALID: assert property (
        o_origin_latch |=> !o_origin_latch && o_origin_valid
        && o_origin_retained == $past(i_axis_type_select))
        else $error("origin status wrong after latch");
    AST_POWER: assert property (
        i_power_up && !o_origin_latch && !o_busy
        |=> o_origin_valid == $past(o_origin_valid && o_origin_retained))
        else $error("origin status wrong after power up");
    AST_IGNORE: assert property (
        !o_busy && i_abs_origin_reset && !i_home_request
        && !i_axis_type_select |-> ##[0:1] (o_ignored && !o_busy))
        else $error("absolute reset not ignored");

    // main scenarios
    COV_INDEX: cover property (take && m3);
    COV_IGNORE: cover property (o_ignored);
    COV_RETAIN: cover property (o_origin_latch && i_axis_type_select);
endmodule : homing_props

bind axis_homing_sequencer homing_props u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_homing_mode_select(i_homing_mode_select),
    .i_axis_type_select(i_axis_type_select),
    .i_homing_option_bits(i_homing_option_bits),
    .i_rotary_axis(i_rotary_axis), .i_home_request(i_home_request),
    .i_abs_origin_reset(i_abs_origin_reset), .i_power_up(i_power_up),
    .i_sense(i_sense), .o_cmd(o_cmd), .o_origin_latch(o_origin_latch),
    .o_origin_valid(o_origin_valid), .o_busy(o_busy),
    .o_origin_retained(o_origin_retained), .o_ignored(o_ignored));

`default_nettype wire

// [test/tb.sv]
// Purpose: directed homing sequences against the drive model
// Assumes: one request at a time, config set before request
// Notes:   outcome is {latch, return, ignored, valid, retained}
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic                    i_clk;
    logic                    i_rst_n;
    logic [5:0]              mode;
    logic [2:0]              opt;
    logic                    axis_abs;
    logic                    rotary;
    logic                    req;
    logic                    abs_rst;
    logic                    pwr_up;
    homing_pkg::axis_sense_t sense;
    homing_pkg::motion_cmd_t cmd;
    logic                    latch;
    logic                    valid;
    logic                    retained;
    logic                    busy;
    logic                    ignored;
    logic [2:0]              seen;
    int                      n_fail = 0;
    int                      compares = 0;
    int                      tn = 0;
    int                      cyc = 0;

    axis_homing_sequencer uut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_homing_mode_select(mode),
        .i_axis_type_select(axis_abs), .i_homing_option_bits(opt),
        .i_rotary_axis(rotary), .i_home_request(req),
        .i_abs_origin_reset(abs_rst), .i_power_up(pwr_up),
        .i_sense(sense), .o_cmd(cmd), .o_origin_latch(latch),
        .o_origin_valid(valid), .o_origin_retained(retained),
        .o_busy(busy), .o_ignored(ignored));
    axis_drive_model drive (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cmd(cmd), .i_origin_latch(latch), .o_sense(sense));

    // clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // collect pulses, cycle ceiling
    always @(negedge i_clk) begin
        seen = seen | {latch === 1'b1, cmd.to_origin === 1'b1,
                       ignored === 1'b1};
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out;
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // compare the outcome vector after settling
    task automatic end_test(input logic [4:0] exp);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        tn++;
        compares++;
        if ({seen, valid, retained} !== exp) begin
            n_fail++;
            $display("unexpected outcome of test %0d: expected %h seen %h",
                     tn, exp, {seen, valid, retained});
        end
        $display("test %0d done", tn);
    endtask : end_test

    // one request; cfg is {absolute, rotary, abs reset}
    task automatic run(input logic [5:0] m, input logic [2:0] op,
                       input logic [2:0] cfg, input logic [4:0] exp);
        int n;
        @(posedge i_clk);
        mode <= m;
        opt <= op;
        {axis_abs, rotary} <= cfg[2:1];
        seen = 3'h0;
        @(posedge i_clk);
        req <= ~cfg[0];
        abs_rst <= cfg[0];
        @(posedge i_clk);
        req <= 1'b0;
        abs_rst <= 1'b0;
        @(posedge i_clk);
        for (n = 0; n < 300 && busy !== 1'b0; n++)
            @(posedge i_clk);
        end_test(exp);
    endtask : run

    task automatic pwr(input logic [4:0] exp);
        @(posedge i_clk);
        seen = 3'h0;
        pwr_up <= 1'b1;
        @(posedge i_clk);
        pwr_up <= 1'b0;
        end_test(exp);
    endtask : pwr

    initial begin
        {mode, opt, axis_abs, rotary, req, abs_rst, pwr_up} = '0;
        seen = 3'h0;
        i_rst_n = 1'b0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        run(6'h01, 3'h1, 3'h0, 5'h12);
        run(6'h01, 3'h1, 3'h0, 5'h0a);
        run(6'h02, 3'h3, 3'h0, 5'h12);
        pwr(5'h00);
        run(6'h04, 3'h0, 3'h0, 5'h12);
        run(6'h04, 3'h3, 3'h0, 5'h12);
        run(6'h03, 3'h0, 3'h1, 5'h06);
        pwr(5'h00);
        run(6'h03, 3'h0, 3'h5, 5'h13);
        pwr(5'h03);
        run(6'h03, 3'h3, 3'h4, 5'h13);
        run(6'h03, 3'h0, 3'h4, 5'h0b);
        run(6'h03, 3'h5, 3'h6, 5'h13);
        run(6'h03, 3'h0, 3'h6, 5'h0b);
        run(6'h01, 3'h2, 3'h4, 5'h13);
        run(6'h00, 3'h0, 3'h0, 5'h12);
        run(6'h05, 3'h0, 3'h0, 5'h02);
        close_out();
    end
endmodule : tb

`default_nettype wire
